// >>> sspc_pkg.sv
package sspc_pkg;
  localparam int          FIFO_DEPTH       = 8;
  localparam logic [3:0]  FIFO_FULL        = 4'h8;
  localparam logic [1:0]  FMT_SPI          = 2'h0;
  localparam logic [1:0]  FMT_PULSE        = 2'h1;
  localparam logic [1:0]  FMT_CMDRESP      = 2'h2;
  localparam logic [4:0]  CMD_BITS         = 5'h08;
  // command bits plus one turnaround clock
  localparam logic [4:0]  REPLY_START      = 5'h09;
  localparam logic [4:0]  MIN_BITS         = 5'h04;
  localparam logic [3:0]  MIN_SIZE         = 4'h3;
  localparam logic [6:0]  PRESCALE_HALF_MIN = 7'h01;
  localparam logic [3:0]  TX_SERVICE_LEVEL = 4'h4;
  localparam logic [3:0]  RX_SERVICE_LEVEL = 4'h4;
  localparam logic [6:0]  RX_TIMEOUT_TICKS = 7'h40;
  localparam logic [1:0]  TAIL_TICKS       = 2'h2;
  localparam logic [1:0]  OB_FULL          = 2'h2;
  localparam int          IRQ_TX           = 0;
  localparam int          IRQ_RX           = 1;
  localparam int          IRQ_TMO          = 2;
  localparam int          IRQ_OVR          = 3;
  localparam logic [3:0]  IRQ_RESET        = 4'h0;
  typedef enum logic [2:0] {M_IDLE, M_PULSE, M_RUN, M_TAIL, M_GAP} mstate_t;
endpackage : sspc_pkg

// >>> sync_serial_port_core.sv
`timescale 1ns/1ps
module sync_serial_port_core
  import sspc_pkg::*;
(
  input  logic        CLK_SYS,
  input  logic        RESETN,
  input  logic        ENABLE,
  input  logic        MASTER,
  input  logic [1:0]  FORMAT,
  input  logic [3:0]  DATA_SIZE,
  input  logic        CLOCK_POLARITY,
  input  logic        CLOCK_PHASE,
  input  logic [7:0]  PRESCALE_DIVISOR,
  input  logic [7:0]  SERIAL_CLOCK_RATE,
  input  logic [3:0]  INTERRUPT_MASK,
  input  logic [3:0]  INTERRUPT_CLEAR,
  input  logic        TX_WRITE,
  input  logic [15:0] TX_DATA,
  output logic        TX_READY,
  input  logic        RX_READ,
  output logic [15:0] RX_DATA,
  output logic        RX_VALID,
  output logic [3:0]  RAW_STATUS,
  output logic [3:0]  MASKED_STATUS,
  output logic        IRQ,
  input  logic        SCK_IN,
  output logic        SCK_OUT,
  output logic        SCK_OE_N,
  input  logic        FSS_IN,
  output logic        FSS_OUT,
  output logic        FSS_OE_N,
  input  logic        SERIAL_IN,
  output logic        SERIAL_OUT,
  output logic        SERIAL_OUT_OE_N
);

  function automatic logic txbit(input logic [15:0] w, input logic [4:0] i,
                                 input logic m, input logic [4:0] n);
    logic r;
    r = 1'b0;
    if (m)
    begin
      if (i < CMD_BITS)
        r = w[3'h7 - i[2:0]];
    end
    else if (i < n)
      r = w[4'(n - 5'h01 - i)];
    return r;
  endfunction : txbit

  logic [15:0] tx_mem [FIFO_DEPTH];
  logic [2:0]  tx_wp, tx_rp;
  logic [3:0]  tx_cnt;
  logic [15:0] rx_mem [FIFO_DEPTH];
  logic [2:0]  rx_wp, rx_rp;
  logic [3:0]  rx_cnt;
  logic [15:0] ob_data [2];
  logic [1:0]  ob_cnt, next_ob_cnt;
  logic [6:0]  pre_cnt, pre_half, tmo_cnt;
  logic [7:0]  scr_cnt;
  logic        tick, ti, mw, spi, pol, eff_phase;
  logic [4:0]  nbits, tot, bidx;
  mstate_t     mstate;
  logic [1:0]  tail_cnt;
  logic        sck_m, fss_m, sck_d, fss_d;
  logic        m_lead, m_trail, s_act, s_lead, s_trail;
  logic        ev_lead, ev_trail, ev_start, done, abort, sample, change;
  logic        busy, rx_pend, m_cont;
  logic [15:0] word, load_word, rx_sh, next_rx_sh, rx_word, rx_hold;
  logic        tx_push, tx_pop, rx_push, rx_ok, ovr_set, tmo_set, mv, ob_rd;
  logic [3:0]  next_tx_cnt, raw;
  logic        tmo, ovr;

  assign ti = (FORMAT == FMT_PULSE);
  assign mw = (FORMAT == FMT_CMDRESP);
  assign spi = !ti && !mw;
  assign pol = spi && CLOCK_POLARITY;
  assign eff_phase = ti || (spi && CLOCK_PHASE);
  assign nbits = (DATA_SIZE < MIN_SIZE) ? MIN_BITS : 5'({1'b0, DATA_SIZE} + 5'h01);
  assign tot = mw ? 5'(nbits + REPLY_START) : nbits;

  // odd prescale values lose their low bit so the divisor stays even
  assign pre_half = (PRESCALE_DIVISOR[7:1] < PRESCALE_HALF_MIN) ?
                    PRESCALE_HALF_MIN : PRESCALE_DIVISOR[7:1];
  assign tick = ENABLE && (pre_cnt == 7'(pre_half - 7'h01))
                && (scr_cnt == SERIAL_CLOCK_RATE);

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      pre_cnt <= 7'h00;
      scr_cnt <= 8'h00;
    end
    else if (!ENABLE)
    begin
      pre_cnt <= 7'h00;
      scr_cnt <= 8'h00;
    end
    else if (pre_cnt == 7'(pre_half - 7'h01))
    begin
      pre_cnt <= 7'h00;
      scr_cnt <= (scr_cnt == SERIAL_CLOCK_RATE) ? 8'h00 : 8'(scr_cnt + 8'h01);
    end
    else
      pre_cnt <= 7'(pre_cnt + 7'h01);
  end

  // edges of the bit clock, normalised so that the lead edge leaves idle
  assign m_lead = tick && (mstate == M_RUN) && (sck_m == pol);
  assign m_trail = tick && (mstate == M_RUN) && (sck_m != pol);
  assign s_act = ENABLE && !MASTER;
  assign s_lead = s_act && ((SCK_IN ^ pol) && !(sck_d ^ pol));
  assign s_trail = s_act && (!(SCK_IN ^ pol) && (sck_d ^ pol));
  assign ev_lead = MASTER ? m_lead : s_lead;
  assign ev_trail = MASTER ? m_trail : s_trail;
  assign done = busy && ev_trail && (bidx == 5'(tot - 5'h01));
  assign sample = busy && (eff_phase ? ev_trail : ev_lead)
                  && (!mw || bidx >= REPLY_START);
  assign change = busy && !done && (eff_phase ? ev_lead : ev_trail);
  assign m_cont = spi && CLOCK_PHASE && (tx_cnt != 4'h0);
  assign abort = s_act && !ti && FSS_IN && busy;

  always_comb
  begin
    ev_start = 1'b0;
    if (ENABLE && MASTER)
      ev_start = (mstate == M_IDLE && tick && tx_cnt != 4'h0 && !ti)
                 || (mstate == M_PULSE && tick)
                 || (mstate == M_RUN && done && m_cont);
    else if (s_act)
    begin
      if (ti)
        ev_start = s_trail && FSS_IN && (!busy || done);
      else
        ev_start = (fss_d && !FSS_IN)
                   || (done && !FSS_IN && eff_phase && spi);
    end
  end

  // an empty fifo leaves the read slot holding the word written eight pushes ago
  assign tx_pop = ev_start && (tx_cnt != 4'h0);
  assign load_word = tx_mem[tx_rp];
  assign tx_push = TX_WRITE && TX_READY;
  assign next_tx_cnt = 4'(tx_cnt + {3'h0, tx_push} - {3'h0, tx_pop});

  assign next_rx_sh = sample ? {rx_sh[14:0], SERIAL_IN} : rx_sh;
  assign rx_word = next_rx_sh & ~(16'hffff << nbits);
  assign rx_push = ti ? (rx_pend && (MASTER ? tick : s_lead)) : done;
  assign mv = (rx_cnt != 4'h0) && ((ob_cnt != OB_FULL) || ob_rd);
  assign rx_ok = rx_push && ((rx_cnt != FIFO_FULL) || mv);
  assign ovr_set = rx_push && !rx_ok;
  assign ob_rd = RX_READ && (ob_cnt != 2'h0);
  assign next_ob_cnt = 2'(ob_cnt + {1'b0, mv} - {1'b0, ob_rd});

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      mstate <= M_IDLE;
      sck_m <= 1'b0;
      fss_m <= 1'b1;
      tail_cnt <= 2'h0;
    end
    else if (!ENABLE || !MASTER)
    begin
      mstate <= M_IDLE;
      sck_m <= pol;
      fss_m <= !ti;
      tail_cnt <= 2'h0;
    end
    else
    begin
      unique case (mstate)
        M_IDLE:
        begin
          sck_m <= pol;
          fss_m <= !ti;
          if (tick && tx_cnt != 4'h0)
          begin
            if (ti)
            begin
              mstate <= M_PULSE;
              fss_m <= 1'b1;
              sck_m <= 1'b1;
            end
            else
            begin
              mstate <= M_RUN;
              fss_m <= 1'b0;
            end
          end
        end
        M_PULSE:
          if (tick)
          begin
            sck_m <= 1'b0;
            mstate <= M_RUN;
          end
        M_RUN:
          if (tick)
          begin
            sck_m <= !sck_m;
            if (ti)
              fss_m <= 1'b0;
            if (done && !m_cont)
            begin
              mstate <= ti ? M_GAP : M_TAIL;
              tail_cnt <= 2'h0;
            end
          end
        M_TAIL:
          if (tick)
          begin
            tail_cnt <= 2'(tail_cnt + 2'h1);
            if (tail_cnt == 2'(TAIL_TICKS - 2'h1))
            begin
              fss_m <= 1'b1;
              mstate <= M_GAP;
            end
          end
        M_GAP:
          if (tick)
            mstate <= M_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      busy <= 1'b0;
      bidx <= 5'h00;
      word <= 16'h0000;
      SERIAL_OUT <= 1'b0;
      rx_sh <= 16'h0000;
      rx_hold <= 16'h0000;
      rx_pend <= 1'b0;
      sck_d <= 1'b0;
      fss_d <= 1'b1;
    end
    else
    begin
      sck_d <= SCK_IN;
      fss_d <= FSS_IN;
      rx_sh <= next_rx_sh;
      if (done && ti)
      begin
        rx_hold <= rx_word;
        rx_pend <= 1'b1;
      end
      else if (rx_push)
        rx_pend <= 1'b0;
      if (!ENABLE)
      begin
        busy <= 1'b0;
        SERIAL_OUT <= 1'b0;
      end
      else if (ev_start)
      begin
        busy <= 1'b1;
        bidx <= 5'h00;
        word <= load_word;
        SERIAL_OUT <= eff_phase ? 1'b0 : txbit(load_word, 5'h00, mw, nbits);
      end
      else if (done || abort)
      begin
        busy <= 1'b0;
        SERIAL_OUT <= 1'b0;
      end
      else
      begin
        if (busy && ev_trail)
          bidx <= 5'(bidx + 5'h01);
        if (change)
          SERIAL_OUT <= txbit(word, eff_phase ? bidx : 5'(bidx + 5'h01), mw, nbits);
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      SCK_OUT <= 1'b0;
      FSS_OUT <= 1'b1;
      SCK_OE_N <= 1'b1;
      FSS_OE_N <= 1'b1;
      SERIAL_OUT_OE_N <= 1'b1;
    end
    else
    begin
      SCK_OUT <= sck_m;
      FSS_OUT <= fss_m;
      SCK_OE_N <= !(ENABLE && MASTER);
      FSS_OE_N <= !(ENABLE && MASTER);
      if (MASTER)
        SERIAL_OUT_OE_N <= !ENABLE || (ti && !busy);
      else
        SERIAL_OUT_OE_N <= !(s_act && (busy || (!ti && !FSS_IN)));
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tx_wp <= 3'h0;
      tx_rp <= 3'h0;
      tx_cnt <= 4'h0;
      TX_READY <= 1'b0;
      for (int i = 0; i < FIFO_DEPTH; i++)
        tx_mem[i] <= 16'h0000;
    end
    else
    begin
      if (tx_push)
      begin
        tx_mem[tx_wp] <= TX_DATA;
        tx_wp <= 3'(tx_wp + 3'h1);
      end
      if (tx_pop)
        tx_rp <= 3'(tx_rp + 3'h1);
      tx_cnt <= next_tx_cnt;
      TX_READY <= (next_tx_cnt != FIFO_FULL);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rx_wp <= 3'h0;
      rx_rp <= 3'h0;
      rx_cnt <= 4'h0;
      ob_cnt <= 2'h0;
      RX_VALID <= 1'b0;
      ob_data[0] <= 16'h0000;
      ob_data[1] <= 16'h0000;
      for (int i = 0; i < FIFO_DEPTH; i++)
        rx_mem[i] <= 16'h0000;
    end
    else
    begin
      if (rx_ok)
      begin
        rx_mem[rx_wp] <= ti ? rx_hold : rx_word;
        rx_wp <= 3'(rx_wp + 3'h1);
      end
      if (mv)
        rx_rp <= 3'(rx_rp + 3'h1);
      rx_cnt <= 4'(rx_cnt + {3'h0, rx_ok} - {3'h0, mv});
      // two-entry skid stage keeps a stalled reader from losing a word
      if (ob_rd)
        ob_data[0] <= ob_data[1];
      if (mv)
        ob_data[1'(ob_cnt - {1'b0, ob_rd})] <= rx_mem[rx_rp];
      ob_cnt <= next_ob_cnt;
      RX_VALID <= (next_ob_cnt != 2'h0);
    end
  end
  assign RX_DATA = ob_data[0];

  assign tmo_set = tick && (tmo_cnt == 7'(RX_TIMEOUT_TICKS - 7'h01))
                   && !ev_lead && !ev_trail
                   && ((rx_cnt != 4'h0) || (ob_cnt != 2'h0));
  assign raw = {ovr_set || (ovr && !INTERRUPT_CLEAR[IRQ_OVR]),
                tmo_set || (tmo && !INTERRUPT_CLEAR[IRQ_TMO]),
                rx_cnt >= RX_SERVICE_LEVEL,
                tx_cnt <= TX_SERVICE_LEVEL};

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tmo_cnt <= 7'h00;
      tmo <= 1'b0;
      ovr <= 1'b0;
      RAW_STATUS <= IRQ_RESET;
      MASKED_STATUS <= IRQ_RESET;
      IRQ <= 1'b0;
    end
    else
    begin
      if (ev_lead || ev_trail || (rx_cnt == 4'h0 && ob_cnt == 2'h0))
        tmo_cnt <= 7'h00;
      else if (tick && tmo_cnt != RX_TIMEOUT_TICKS)
        tmo_cnt <= 7'(tmo_cnt + 7'h01);
      tmo <= raw[IRQ_TMO];
      ovr <= raw[IRQ_OVR];
      RAW_STATUS <= raw;
      MASKED_STATUS <= raw & INTERRUPT_MASK;
      IRQ <= |(raw & INTERRUPT_MASK);
    end
  end

endmodule : sync_serial_port_core

// >>> sspc_asserts.sv
`timescale 1ns/1ps
module sspc_asserts
  import sspc_pkg::*;
(
  input logic        CLK_SYS,
  input logic        RESETN,
  input logic        ENABLE,
  input logic        MASTER,
  input logic [1:0]  FORMAT,
  input logic        CLOCK_POLARITY,
  input logic [7:0]  PRESCALE_DIVISOR,
  input logic [7:0]  SERIAL_CLOCK_RATE,
  input logic [3:0]  INTERRUPT_MASK,
  input logic [3:0]  INTERRUPT_CLEAR,
  input logic        TX_WRITE,
  input logic        TX_READY,
  input logic        RX_READ,
  input logic [15:0] RX_DATA,
  input logic        RX_VALID,
  input logic [3:0]  RAW_STATUS,
  input logic [3:0]  MASKED_STATUS,
  input logic        IRQ,
  input logic        SCK_OUT,
  input logic        SCK_OE_N,
  input logic        FSS_OUT
);
  logic        armed;
  logic [15:0] hi_cnt;
  logic [15:0] two_h;
  logic        pulse_m;
  logic        spi_m;
  assign pulse_m = ENABLE && MASTER && FORMAT == FMT_PULSE;
  assign spi_m   = ENABLE && MASTER && FORMAT == FMT_SPI;
  // one serial period is two divider ticks
  assign two_h = 16'(PRESCALE_DIVISOR & 8'hfe) * (16'(SERIAL_CLOCK_RATE) + 16'h1);
  // counts only pulses that began properly, so enable edges are not judged
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      armed  <= 1'b0;
      hi_cnt <= 16'h0;
    end
    else if (pulse_m && $rose(FSS_OUT) && $rose(SCK_OUT))
    begin
      armed  <= 1'b1;
      hi_cnt <= 16'h1;
    end
    else if (armed && FSS_OUT)
      hi_cnt <= hi_cnt + 16'h1;
    else
      armed <= 1'b0;
  end
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);
  sequence s_pulse_rise;
    pulse_m && $rose(FSS_OUT);
  endsequence
  sequence s_pulse_fall;
    armed && !FSS_OUT;
  endsequence
  property p_tx_full;
    $fell(TX_READY) |-> $past(TX_WRITE);
  endproperty
  property p_rx_pop;
    $fell(RX_VALID) |-> $past(RX_READ);
  endproperty
  property p_rx_hold;
    RX_VALID && !RX_READ |=> RX_VALID && $stable(RX_DATA);
  endproperty
  property p_mask;
    (INTERRUPT_MASK == 4'h0) [*3] |-> !IRQ && MASKED_STATUS == 4'h0;
  endproperty
  property p_irq;
    (MASKED_STATUS != 4'h0) [*2] |-> IRQ;
  endproperty
  property p_ovr_sticky;
    RAW_STATUS[IRQ_OVR] && !INTERRUPT_CLEAR[IRQ_OVR] |=> RAW_STATUS[IRQ_OVR];
  endproperty
  property p_idle_clk;
    (spi_m && FSS_OUT) [*3] |-> SCK_OUT == CLOCK_POLARITY;
  endproperty
  property p_frame;
    spi_m && $changed(SCK_OUT) |-> !FSS_OUT;
  endproperty
  property p_oe;
    $stable(ENABLE) && $stable(MASTER) |-> SCK_OE_N == !(ENABLE && MASTER);
  endproperty
  property p_pulse_start;
    s_pulse_rise |-> $rose(SCK_OUT);
  endproperty
  property p_pulse_len;
    s_pulse_fall |-> hi_cnt == two_h;
  endproperty
  a_tx_full: assert property (p_tx_full) else $error("tx ready fell without write");
  a_rx_pop: assert property (p_rx_pop) else $error("rx valid fell without read");
  a_rx_hold: assert property (p_rx_hold) else $error("rx word not held");
  a_mask: assert property (p_mask) else $error("masked source reached irq");
  a_irq: assert property (p_irq) else $error("irq missing");
  a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun lost");
  a_idle_clk: assert property (p_idle_clk) else $error("idle clock level");
  a_frame: assert property (p_frame) else $error("clock moved outside frame");
  a_oe: assert property (p_oe) else $error("clock pad enable");
  a_pulse_start: assert property (p_pulse_start) else $error("pulse not on rise");
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length");
endmodule : sspc_asserts

bind sync_serial_port_core sspc_asserts chk (
  .CLK_SYS, .RESETN, .ENABLE, .MASTER, .FORMAT, .CLOCK_POLARITY, .PRESCALE_DIVISOR,
  .SERIAL_CLOCK_RATE, .INTERRUPT_MASK, .INTERRUPT_CLEAR, .TX_WRITE, .TX_READY, .RX_READ,
  .RX_DATA, .RX_VALID, .RAW_STATUS, .MASKED_STATUS, .IRQ, .SCK_OUT, .SCK_OE_N, .FSS_OUT
);

// >>> sspc_peer.sv
`timescale 1ns/1ps
// spi slave, clock idle low, phase zero; echoes the previous frame
module sspc_peer (
  input  logic        sck,
  input  logic        fss,
  input  logic        mosi,
  input  logic [3:0]  size,
  input  logic        cmd,
  output logic        miso,
  output logic [15:0] got
);
  logic [15:0] sh = 16'h0;
  logic        b;
  always @(posedge sck)
    if (!fss)
      b <= mosi;
  always @(negedge sck)
    if (!fss)
      sh <= {sh[14:0], b};
  always @(posedge fss)
    got <= sh;
  // unselected line shows the inverse, never a stale copy
  // command mode: after one idle clock the byte reply repeats the command
  assign miso = fss ? ~sh[size] : (cmd ? sh[8] : sh[size]);
endmodule : sspc_peer

// >>> sync_serial_port_core_tb.sv
`timescale 1ns/1ps
module sync_serial_port_core_tb
  import sspc_pkg::*;
;
  logic        CLK_SYS = 1'b0, RESETN = 1'b0, ENABLE = 1'b0, MASTER = 1'b0;
  logic        CLOCK_POLARITY = 1'b0, CLOCK_PHASE = 1'b0, TX_WRITE = 1'b0, RX_READ = 1'b0;
  logic        SCK_IN = 1'b0, FSS_IN = 1'b1;
  logic [1:0]  FORMAT = FMT_SPI;
  logic [3:0]  DATA_SIZE = 4'h7, INTERRUPT_MASK = 4'h0, INTERRUPT_CLEAR = 4'h0;
  logic [7:0]  PRESCALE_DIVISOR = 8'h04, SERIAL_CLOCK_RATE = 8'h01;
  logic [15:0] TX_DATA = 16'h0;
  logic        TX_READY, RX_VALID, IRQ, SCK_OUT, SCK_OE_N, FSS_OUT, FSS_OE_N;
  logic        SERIAL_IN, SERIAL_OUT, SERIAL_OUT_OE_N;
  logic [15:0] RX_DATA, peer_got, got, wd, m;
  logic [15:0] hist = 16'h0;
  logic [15:0] exp_q[$];
  logic [3:0]  MASKED_STATUS, RAW_STATUS;
  int          fail_count = 0, cmp_count = 0;
  logic [3:0]  sz[3] = '{4'h3, 4'h7, 4'hf};
  logic [15:0] wv[3] = '{16'h0009, 16'h00a5, 16'hbeef};

  always #20 CLK_SYS = ~CLK_SYS;

  sync_serial_port_core dut (
    .CLK_SYS, .RESETN, .ENABLE, .MASTER, .FORMAT, .DATA_SIZE, .CLOCK_POLARITY, .CLOCK_PHASE,
    .PRESCALE_DIVISOR, .SERIAL_CLOCK_RATE, .INTERRUPT_MASK, .INTERRUPT_CLEAR, .TX_WRITE,
    .TX_DATA, .TX_READY, .RX_READ, .RX_DATA, .RX_VALID, .RAW_STATUS, .MASKED_STATUS, .IRQ,
    .SCK_IN, .SCK_OUT, .SCK_OE_N, .FSS_IN, .FSS_OUT, .FSS_OE_N, .SERIAL_IN, .SERIAL_OUT,
    .SERIAL_OUT_OE_N
  );
  sspc_peer peer (.sck(SCK_OUT), .fss(FSS_OUT), .mosi(SERIAL_OUT), .size(DATA_SIZE),
    .cmd(FORMAT == FMT_CMDRESP), .miso(SERIAL_IN), .got(peer_got));

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [15:0] w);
    @(negedge CLK_SYS);
    for (int n = 0; n < 3000 && TX_READY !== 1'b1; n++) @(negedge CLK_SYS);
    TX_WRITE = 1'b1;
    TX_DATA = w;
    @(negedge CLK_SYS);
    TX_WRITE = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] exp);
    @(negedge CLK_SYS);
    for (int n = 0; n < 3000 && RX_VALID !== 1'b1; n++) @(negedge CLK_SYS);
    check("rx data", exp, RX_DATA);
    RX_READ = 1'b1;
    @(negedge CLK_SYS);
    RX_READ = 1'b0;
  endtask : rd

  // bench as master, 16 system cycles per bit, byte frames
  task automatic slave_xfer(output logic [15:0] w);
    w = 16'h0;
    repeat (8) @(negedge CLK_SYS);
    FSS_IN = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      repeat (8) @(negedge CLK_SYS);
      SCK_IN = 1'b1;
      w = {w[14:0], SERIAL_OUT};
      repeat (8) @(negedge CLK_SYS);
      SCK_IN = 1'b0;
    end
    repeat (8) @(negedge CLK_SYS);
    FSS_IN = 1'b1;
  endtask : slave_xfer

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  // the whole sequence needs about 2300 cycles
  initial
  begin
    repeat (40000) @(posedge CLK_SYS);
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    repeat (4) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    RESETN = 1'b1;
    @(negedge CLK_SYS);
    check("tx ready", 16'h1, TX_READY);
    check("sck oe_n", 16'h1, SCK_OE_N);
    done("reset");
    ENABLE = 1'b1;
    slave_xfer(got);
    check("slave empty word", 16'h0, got);
    rd(16'h00ff);
    check("sck oe_n", 16'h1, SCK_OE_N);
    done("slave empty");
    ENABLE = 1'b0;
    @(negedge CLK_SYS);
    MASTER = 1'b1;
    @(negedge CLK_SYS);
    ENABLE = 1'b1;
    repeat (2) @(negedge CLK_SYS);
    check("sck oe_n", 16'h0, SCK_OE_N);
    check("fss oe_n", 16'h0, FSS_OE_N);
    for (int i = 0; i < 3; i++)
    begin
      DATA_SIZE = sz[i];
      m = 16'hffff >> (15 - int'(sz[i]));
      wr(wv[i]);
      rd(hist & m);
      for (int n = 0; n < 3000 && FSS_OUT !== 1'b1; n++) @(negedge CLK_SYS);
      check("peer word", wv[i] & m, peer_got & m);
      hist = (hist << (int'(sz[i]) + 1)) | (wv[i] & m);
    end
    done("sizes");
    DATA_SIZE = 4'h7;
    ENABLE = 1'b0;
    INTERRUPT_MASK = 4'h8;
    for (int k = 0; k < 11; k++)
    begin
      wd = 16'(k * 37 + 5);
      if (k == 8)
      begin
        @(negedge CLK_SYS);
        check("tx ready full", 16'h0, TX_READY);
        check("tx service", 16'h0, RAW_STATUS[IRQ_TX]);
        // refused: the fifo is full
        TX_WRITE = 1'b1;
        TX_DATA = 16'h00de;
        @(negedge CLK_SYS);
        TX_WRITE = 1'b0;
        ENABLE = 1'b1;
      end
      wr(wd);
      exp_q.push_back(hist & 16'hff);
      hist = (hist << 8) | (wd & 16'hff);
    end
    exp_q.pop_back();
    for (int n = 0; n < 3000 && RAW_STATUS[IRQ_OVR] !== 1'b1; n++) @(negedge CLK_SYS);
    @(negedge CLK_SYS);
    check("overrun", 16'h1, RAW_STATUS[IRQ_OVR]);
    check("masked", 16'h8, MASKED_STATUS);
    check("irq", 16'h1, IRQ);
    check("rx service", 16'h1, RAW_STATUS[IRQ_RX]);
    for (int n = 0; n < 1000 && RAW_STATUS[IRQ_TMO] !== 1'b1; n++) @(negedge CLK_SYS);
    check("timeout", 16'h1, RAW_STATUS[IRQ_TMO]);
    check("tx service", 16'h1, RAW_STATUS[IRQ_TX]);
    INTERRUPT_MASK = 4'h0;
    repeat (3) @(negedge CLK_SYS);
    check("irq masked", 16'h0, IRQ);
    INTERRUPT_CLEAR = 4'hc;
    @(negedge CLK_SYS);
    INTERRUPT_CLEAR = 4'h0;
    @(negedge CLK_SYS);
    check("overrun cleared", 16'h0, RAW_STATUS[IRQ_OVR]);
    foreach (exp_q[i]) rd(exp_q[i]);
    done("overrun");
    ENABLE = 1'b0;
    @(negedge CLK_SYS);
    MASTER = 1'b0;
    @(negedge CLK_SYS);
    ENABLE = 1'b1;
    slave_xfer(got);
    check("slave replay", 16'(3 * 37 + 5) & 16'hff, got);
    rd(hist[7] ? 16'h0000 : 16'h00ff);
    done("slave replay");
    ENABLE = 1'b0;
    CLOCK_POLARITY = 1'b1;
    CLOCK_PHASE = 1'b1;
    @(negedge CLK_SYS);
    MASTER = 1'b1;
    // pad must settle before the frame checker watches it again
    repeat (3) @(negedge CLK_SYS);
    ENABLE = 1'b1;
    repeat (3) @(negedge CLK_SYS);
    check("idle clock high", 16'h1, SCK_OUT);
    ENABLE = 1'b0;
    CLOCK_POLARITY = 1'b0;
    repeat (3) @(negedge CLK_SYS);
    ENABLE = 1'b1;
    wr(16'h003c);
    wr(16'h0096);
    for (int n = 0; n < 3000 && FSS_OUT !== 1'b0; n++) @(negedge CLK_SYS);
    for (int n = 0; n < 3000 && FSS_OUT !== 1'b1; n++) @(negedge CLK_SYS);
    // one unbroken select shows both words to the partner
    check("phase one pair", 16'h3c96, peer_got);
    rd(hist & 16'hff);
    rd(16'h003c);
    done("phase one");
    ENABLE = 1'b0;
    CLOCK_PHASE = 1'b0;
    FORMAT = FMT_PULSE;
    repeat (2) @(negedge CLK_SYS);
    ENABLE = 1'b1;
    repeat (4) @(negedge CLK_SYS);
    check("pulse idle fss", 16'h0, FSS_OUT);
    check("pulse idle oe_n", 16'h1, SERIAL_OUT_OE_N);
    wr(16'h005a);
    for (int n = 0; n < 3000 && RX_VALID !== 1'b1; n++) @(negedge CLK_SYS);
    check("pulse rx", 16'h1, RX_VALID);
    RX_READ = 1'b1;
    @(negedge CLK_SYS);
    RX_READ = 1'b0;
    done("pulse");
    ENABLE = 1'b0;
    FORMAT = FMT_CMDRESP;
    repeat (2) @(negedge CLK_SYS);
    ENABLE = 1'b1;
    wr(16'h00c3);
    rd(16'h00c3);
    for (int n = 0; n < 3000 && FSS_OUT !== 1'b1; n++) @(negedge CLK_SYS);
    // seven command bits left in view, then nine quiet bits
    check("command frame", 16'h8600, peer_got);
    done("command");
    report_and_stop();
  end
endmodule : sync_serial_port_core_tb
